// *** core/apc_pkg.sv ***
// apc_pkg: register map, field positions, reset values and carriers
// for the audio port clock routing block; shared by core modules.
package apc_pkg;

   // register indices; byte address on the bus is four times the index
   localparam logic [7:0] IDX_IF_DIR     = 8'h1B;
   localparam logic [7:0] IDX_PORT_SET3  = 8'h1D;
   localparam logic [7:0] IDX_BDIV       = 8'h1E;
   localparam logic [7:0] IDX_SEC_SRC    = 8'h1F;
   localparam logic [7:0] IDX_PRI_SEC    = 8'h20;
   localparam logic [7:0] IDX_OUT_ROUTE  = 8'h21;
   localparam logic [7:0] IDX_MISC       = 8'h22;
   localparam logic [7:0] IDX_STATUS     = 8'h30;

   // writable bits of each register
   localparam logic [7:0] MSK_IF_DIR     = 8'h0C;
   localparam logic [7:0] MSK_PORT_SET3  = 8'hFF;
   localparam logic [7:0] MSK_BDIV       = 8'hFF;
   localparam logic [7:0] MSK_SEC_SRC    = 8'h79;
   localparam logic [7:0] MSK_PRI_SEC    = 8'h0D;
   localparam logic [7:0] MSK_OUT_ROUTE  = 8'hFF;
   localparam logic [7:0] MSK_MISC       = 8'h20;

   // values after reset
   localparam logic [7:0] RST_REG        = 8'h00;
   localparam logic [7:0] RST_BDIV       = 8'h01;

   // field positions
   localparam int BIT_BCLK_DIR   = 3;
   localparam int BIT_WCLK_DIR   = 2;
   localparam int BIT_BCLK_INV   = 3;
   localparam int BIT_BUF_PWR    = 2;
   localparam int LSB_DIV_SRC    = 0;
   localparam int BIT_DIV_PWR    = 7;
   localparam int LSB_DIV_RATIO  = 0;
   localparam int LSB_SEC_BCLK   = 5;
   localparam int LSB_SEC_WCLK   = 3;
   localparam int BIT_SEC_DIN    = 0;
   localparam int BIT_USE_SBCLK  = 3;
   localparam int BIT_USE_SWCLK  = 2;
   localparam int BIT_USE_SDIN   = 0;
   localparam int BIT_BCLK_OSEL  = 7;
   localparam int BIT_SBCLK_OSEL = 6;
   localparam int LSB_WCLK_OSEL  = 4;
   localparam int LSB_SWCLK_OSEL = 2;
   localparam int BIT_DOUT_LOOP  = 1;
   localparam int BIT_SDOUT_LOOP = 0;
   localparam int BIT_GEN_CALL   = 5;

   // selector codes
   localparam logic [1:0] DIVSRC_CONV = 2'h0;
   localparam logic [1:0] DIVSRC_MOD  = 2'h1;
   localparam logic [1:0] SRC_GPIO    = 2'h0;
   localparam logic [1:0] SRC_SCLK    = 2'h1;
   localparam logic [1:0] SRC_MISO    = 2'h2;
   localparam logic [1:0] SRC_DOUT    = 2'h3;
   localparam logic [1:0] WOSEL_FS    = 2'h0;
   localparam logic [1:0] WOSEL_SEC   = 2'h2;
   localparam logic [1:0] SWOSEL_PIN  = 2'h0;
   localparam logic [1:0] SWOSEL_FS   = 2'h1;

   // ratio field value zero divides by this
   localparam logic [7:0] DIV_ZERO_N  = 8'h80;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      logic bclk;
      logic wclk;
      logic din;
      logic gpio;
      logic sclk;
      logic miso;
      logic dout_pin;
      logic conv_clk;
      logic converter_modulator_clock;
      logic converter_sample_rate_clock;
   } apc_pin_in_t;

   typedef struct packed {
      logic bclk;
      logic bclk_oe;
      logic wclk;
      logic wclk_oe;
      logic dout;
      logic sec_bclk;
      logic sec_wclk;
      logic sec_dout;
   } apc_pin_out_t;

   typedef struct packed {
      logic if_bclk;
      logic if_wclk;
      logic if_din;
      logic div_pwr;
      logic buf_pd;
      logic gc_accept;
   } apc_core_out_t;

endpackage

// *** core/apc_bdiv.sv ***
// apc_bdiv: bit-clock divider, counts rising edges of its input clock.
// assumes tick and level come from synchronised logic on SYS_CLK_I.
`timescale 1ns/100ps
`default_nettype none
module apc_bdiv (
   input  wire logic       SYS_CLK_I,
   input  wire logic       NRST_I,
   input  wire logic       EN_I,
   input  wire logic       TICK_I,
   input  wire logic       LVL_I,
   input  wire logic [6:0] RATIO_I,
   output logic            CLK_O
);
   import apc_pkg::*;

   typedef struct packed {
      logic [7:0] cnt;
      logic       out;
   } apc_bdiv_st_t;

   apc_bdiv_st_t st_r;
   apc_bdiv_st_t st_nxt;
   logic [7:0]   n;
   logic [7:0]   half;

   always_comb begin
      st_nxt = st_r;
      n      = (RATIO_I == 7'h00) ? DIV_ZERO_N : {1'b0, RATIO_I};
      half   = 8'((9'(n) + 9'h001) >> 1);
      if (!EN_I) begin
         st_nxt.cnt = 8'h00;
         st_nxt.out = 1'b0;
      end else begin
         if (TICK_I) begin
            st_nxt.cnt = (st_r.cnt + 8'h01 >= n) ? 8'h00
                                                 : st_r.cnt + 8'h01;
         end
         // divide by one follows the input itself
         st_nxt.out = (n == 8'h01) ? LVL_I : (st_nxt.cnt < half);
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!NRST_I) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign CLK_O = st_r.out;
endmodule
`default_nettype wire

// *** core/apc_top.sv ***
// apc_top: audio port clock and data routing with AHB-Lite registers.
// assumes pins are asynchronous to SYS_CLK_I and are resynchronised;
// GC_DET_I comes from the control interface on the same clock.
// Operation
// - polarity bit inverts the audio bit clock
// - buffer bit powers down buffers with codec
// - divider input 00 converter, 01 modulator clock
// - divider runs only while power bit set
// - ratio divides by value, zero means 128
// - secondary bit clock from gpio/sclk/miso/dout
// - secondary word clock from gpio/sclk/miso/dout
// - secondary data in from gpio or sclk
// - interface bit clock primary or secondary
// - interface word clock primary or secondary
// - interface data in primary or secondary
// - bit-clock output generated or secondary input
// - secondary bit-clock output pin or generated
// - word-clock output sample clock or secondary
// - secondary word-clock output pin or sample clock
// - data-out pin loops back secondary data
// - secondary data out loops back data in
// - general call accepted only when enabled
// - bit-clock pin driven only when direction set
// - word-clock pin driven only when direction set
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module apc_top (
   input  wire logic                   SYS_CLK_I,
   input  wire logic                   NRST_I,
   input  wire logic                   HSEL_I,
   input  wire logic [31:0]            HADDR_I,
   input  wire logic [1:0]             HTRANS_I,
   input  wire logic                   HWRITE_I,
   input  wire logic [2:0]             HSIZE_I,
   input  wire logic [31:0]            HWDATA_I,
   input  wire logic                   HREADY_I,
   output logic                        HREADYOUT_O,
   output logic                        HRESP_O,
   output logic [31:0]                 HRDATA_O,
   input  wire apc_pkg::apc_pin_in_t   PIN_I,
   output apc_pkg::apc_pin_out_t       PIN_O,
   input  wire logic                   CODEC_PD_I,
   input  wire logic                   GC_DET_I,
   output apc_pkg::apc_core_out_t      CORE_O
);
   import apc_pkg::*;

   typedef struct packed {
      logic [7:0]    if_dir;
      logic [7:0]    set3;
      logic [7:0]    bdiv;
      logic [7:0]    sec_src;
      logic [7:0]    pri_sec;
      logic [7:0]    out_route;
      logic [7:0]    misc;
      logic          wr_pend;
      logic [7:0]    wr_idx;
      logic [31:0]   rdata;
      apc_pin_in_t   s1;
      apc_pin_in_t   s2;
      logic          div_prev;
      apc_pin_out_t  po;
      apc_core_out_t co;
   } apc_top_st_t;

   apc_top_st_t st_r;
   apc_top_st_t st_nxt;

   logic       gen_bclk;
   logic       div_in;
   logic       div_tick;
   logic       sec_bclk;
   logic       sec_wclk;
   logic       sec_din;
   logic       pri_bclk;
   logic       addr_ok;
   logic [7:0] a_idx;
   logic [7:0] wv;

   function automatic logic sel4(input logic [1:0] code,
                                 input apc_pin_in_t p);
      logic r;
      r = 1'b0;
      unique case (code)
         SRC_GPIO: r = p.gpio;
         SRC_SCLK: r = p.sclk;
         SRC_MISO: r = p.miso;
         SRC_DOUT: r = p.dout_pin;
      endcase
      return r;
   endfunction

   function automatic logic [7:0] rd_reg(input logic [7:0] idx,
                                        input apc_top_st_t s);
      logic [7:0] r;
      r = 8'h00;
      case (idx)
         IDX_IF_DIR:    r = s.if_dir;
         IDX_PORT_SET3: r = s.set3;
         IDX_BDIV:      r = s.bdiv;
         IDX_SEC_SRC:   r = s.sec_src;
         IDX_PRI_SEC:   r = s.pri_sec;
         IDX_OUT_ROUTE: r = s.out_route;
         IDX_MISC:      r = s.misc;
         IDX_STATUS:    r = {3'h0, s.co.buf_pd, s.po.wclk_oe,
                             s.po.bclk_oe, s.po.bclk, s.co.div_pwr};
         default:       r = 8'h00;
      endcase
      return r;
   endfunction

   function automatic logic [7:0] upd(input logic [7:0] old,
                                      input logic [7:0] val,
                                      input logic [7:0] msk);
      return (old & ~msk) | (val & msk);
   endfunction

   apc_bdiv u_bdiv (
      .SYS_CLK_I (SYS_CLK_I),
      .NRST_I    (NRST_I),
      .EN_I      (st_r.bdiv[BIT_DIV_PWR]),
      .TICK_I    (div_tick),
      .LVL_I     (div_in),
      .RATIO_I   (st_r.bdiv[LSB_DIV_RATIO +: 7]),
      .CLK_O     (gen_bclk)
   );

   always_comb begin
      st_nxt = st_r;

      // pin resynchronisers
      st_nxt.s1 = PIN_I;
      st_nxt.s2 = st_r.s1;

      // bus data phase: apply a pending write
      wv = HWDATA_I[7:0];
      st_nxt.wr_pend = 1'b0;
      if (st_r.wr_pend) begin
         unique case (st_r.wr_idx)
            IDX_IF_DIR:
               st_nxt.if_dir = upd(st_r.if_dir, wv, MSK_IF_DIR);
            IDX_PORT_SET3:
               st_nxt.set3 = upd(st_r.set3, wv, MSK_PORT_SET3);
            IDX_BDIV:
               st_nxt.bdiv = upd(st_r.bdiv, wv, MSK_BDIV);
            IDX_SEC_SRC:
               st_nxt.sec_src = upd(st_r.sec_src, wv, MSK_SEC_SRC);
            IDX_PRI_SEC:
               st_nxt.pri_sec = upd(st_r.pri_sec, wv, MSK_PRI_SEC);
            IDX_OUT_ROUTE:
               st_nxt.out_route = upd(st_r.out_route, wv, MSK_OUT_ROUTE);
            IDX_MISC:
               st_nxt.misc = upd(st_r.misc, wv, MSK_MISC);
            default: begin
            end
         endcase
      end

      // bus address phase; read data sees a write just completed
      a_idx   = HADDR_I[9:2];
      addr_ok = HSEL_I && HREADY_I && HTRANS_I == HTRANS_NONSEQ;
      if (addr_ok && HADDR_I[31:10] == 22'h000000) begin
         st_nxt.wr_pend = HWRITE_I;
         st_nxt.wr_idx  = a_idx;
      end
      if (addr_ok && !HWRITE_I) begin
         st_nxt.rdata = (HADDR_I[31:10] == 22'h000000)
                        ? {24'h000000, rd_reg(a_idx, st_nxt)}
                        : 32'h00000000;
      end

      // secondary sources
      sec_bclk = sel4(st_r.sec_src[LSB_SEC_BCLK +: 2], st_r.s2);
      sec_wclk = sel4(st_r.sec_src[LSB_SEC_WCLK +: 2], st_r.s2);
      sec_din  = st_r.sec_src[BIT_SEC_DIN] ? st_r.s2.sclk
                                           : st_r.s2.gpio;
      pri_bclk = st_r.s2.bclk;

      // divider input; forbidden codes give no clock
      unique case (st_r.set3[LSB_DIV_SRC +: 2])
         DIVSRC_CONV: div_in = st_r.s2.conv_clk;
         DIVSRC_MOD:  div_in = st_r.s2.converter_modulator_clock;
         default:     div_in = 1'b0;
      endcase
      st_nxt.div_prev = div_in;
      div_tick = div_in && !st_r.div_prev;

      // audio interface clocks and data
      st_nxt.co.if_bclk = (st_r.pri_sec[BIT_USE_SBCLK] ? sec_bclk
                           : pri_bclk) ^ st_r.set3[BIT_BCLK_INV];
      st_nxt.co.if_wclk = st_r.pri_sec[BIT_USE_SWCLK] ? sec_wclk
                          : st_r.s2.wclk;
      st_nxt.co.if_din  = st_r.pri_sec[BIT_USE_SDIN] ? sec_din
                          : st_r.s2.din;
      st_nxt.co.div_pwr = st_r.bdiv[BIT_DIV_PWR];
      st_nxt.co.buf_pd  = st_r.set3[BIT_BUF_PWR] && CODEC_PD_I;
      st_nxt.co.gc_accept = GC_DET_I && st_r.misc[BIT_GEN_CALL];

      // bit-clock pin
      st_nxt.po.bclk_oe = st_r.if_dir[BIT_BCLK_DIR];
      st_nxt.po.bclk = st_r.if_dir[BIT_BCLK_DIR]
                       && ((st_r.out_route[BIT_BCLK_OSEL] ? sec_bclk
                            : gen_bclk) ^ st_r.set3[BIT_BCLK_INV]);
      st_nxt.po.sec_bclk = st_r.out_route[BIT_SBCLK_OSEL] ? gen_bclk
                           : pri_bclk;

      // word-clock pin; reserved codes hold it low
      st_nxt.po.wclk_oe = st_r.if_dir[BIT_WCLK_DIR];
      unique case (st_r.out_route[LSB_WCLK_OSEL +: 2])
         WOSEL_FS:  st_nxt.po.wclk = st_r.if_dir[BIT_WCLK_DIR]
                    && st_r.s2.converter_sample_rate_clock;
         WOSEL_SEC: st_nxt.po.wclk = st_r.if_dir[BIT_WCLK_DIR]
                    && sec_wclk;
         default:   st_nxt.po.wclk = 1'b0;
      endcase
      unique case (st_r.out_route[LSB_SWCLK_OSEL +: 2])
         SWOSEL_PIN: st_nxt.po.sec_wclk = st_r.s2.wclk;
         SWOSEL_FS:  st_nxt.po.sec_wclk =
                     st_r.s2.converter_sample_rate_clock;
         default:    st_nxt.po.sec_wclk = 1'b0;
      endcase

      // loopback data paths; reserved settings drive low
      st_nxt.po.dout = st_r.out_route[BIT_DOUT_LOOP] && sec_din;
      st_nxt.po.sec_dout = !st_r.out_route[BIT_SDOUT_LOOP]
                           && st_r.s2.din;
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!NRST_I) begin
         st_r      <= '0;
         st_r.bdiv <= RST_BDIV;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign HREADYOUT_O = 1'b1;
   assign HRESP_O     = 1'b0;
   assign HRDATA_O    = st_r.rdata;
   assign PIN_O       = st_r.po;
   assign CORE_O      = st_r.co;
endmodule
`default_nettype wire

// *** verification/apc_partner.sv ***
// apc_partner: host and secondary device pin activity for apc_top.
// assumes the bench clock; pins the block drives are fed back to it.
`timescale 1ns/100ps
`default_nettype none
module apc_partner (
   input  wire logic                  CLK_I,
   input  wire logic                  NRST_I,
   input  wire apc_pkg::apc_pin_out_t DUT_I,
   output apc_pkg::apc_pin_in_t       PIN_O
);
   import apc_pkg::*;
   logic [7:0] cnt_r = 8'h00;
   logic [1:0] m3_r  = 2'h0;
   logic       mod_r = 1'b0;
   always_ff @(posedge CLK_I) begin
      cnt_r <= NRST_I ? cnt_r + 8'h01 : 8'h00;
      m3_r  <= (m3_r == 2'h2 || !NRST_I) ? 2'h0 : m3_r + 2'h1;
      mod_r <= NRST_I && (mod_r ^ (m3_r == 2'h2));
   end
   // each line its own rate so a wrong mux choice shows
   always_comb begin
      PIN_O.bclk = DUT_I.bclk_oe ? DUT_I.bclk : cnt_r[2];
      PIN_O.wclk = DUT_I.wclk_oe ? DUT_I.wclk : cnt_r[5];
      PIN_O.din = cnt_r[1] ^ cnt_r[3];
      PIN_O.gpio = cnt_r[3];
      PIN_O.sclk = cnt_r[1] ^ cnt_r[4];
      PIN_O.miso = cnt_r[4];
      PIN_O.dout_pin = cnt_r[0] ^ cnt_r[2];
      PIN_O.conv_clk = cnt_r[1];
      PIN_O.converter_modulator_clock = mod_r;
      PIN_O.converter_sample_rate_clock = cnt_r[6];
   end
endmodule
`default_nettype wire

// *** verification/apc_checker.sv ***
// apc_checker: routing assertions on the ports of apc_top.
// assumes writes only to mapped indices, 0x10 or 0x30.
`timescale 1ns/100ps
`default_nettype none
module apc_checker (
   input wire logic                   SYS_CLK_I,
   input wire logic                   NRST_I,
   input wire logic                   HSEL_I,
   input wire logic [31:0]            HADDR_I,
   input wire logic [1:0]             HTRANS_I,
   input wire logic                   HWRITE_I,
   input wire logic [31:0]            HWDATA_I,
   input wire apc_pkg::apc_pin_in_t   PIN_I,
   input wire apc_pkg::apc_pin_out_t  PIN_O,
   input wire logic                   CODEC_PD_I,
   input wire logic                   GC_DET_I,
   input wire apc_pkg::apc_core_out_t CORE_O
);
   import apc_pkg::*;
   logic       wr_r;
   logic [7:0] idx_r;
   logic [2:0] q_r;
   // shadow registers keyed by index bits 2:0
   logic [7:0] rg [8];
   wire logic [3:0] srcs = {PIN_I.dout_pin, PIN_I.miso, PIN_I.sclk,
                            PIN_I.gpio};
   wire logic sb = srcs[rg[7][6:5]];
   wire logic sw = srcs[rg[7][4:3]];
   wire logic sd = rg[7][0] ? PIN_I.sclk : PIN_I.gpio;
   wire logic fs = PIN_I.converter_sample_rate_clock;
   wire logic e_bclk = rg[0][3] ? sb : PIN_I.bclk;
   wire logic e_wclk = rg[0][2] ? sw : PIN_I.wclk;
   wire logic e_din = rg[0][0] ? sd : PIN_I.din;
   always_ff @(posedge SYS_CLK_I) begin
      if (!NRST_I) begin
         wr_r <= 1'b0;
         q_r <= 3'h0;
         for (int i = 0; i < 8; i++) begin
            rg[i] <= (i == 6) ? RST_BDIV : RST_REG;
         end
      end else begin
         wr_r <= HSEL_I && HTRANS_I == HTRANS_NONSEQ && HWRITE_I;
         idx_r <= HADDR_I[9:2];
         q_r <= wr_r ? 3'h0 : q_r + {2'h0, q_r != 3'h7};
         if (wr_r && (idx_r[7:3] == 5'h03 || idx_r[7:3] == 5'h04)) begin
            rg[idx_r[2:0]] <= HWDATA_I[7:0];
         end
      end
   end
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!NRST_I);
   // settings unchanged long enough for every pipeline to flush
   sequence quiet;
      q_r == 3'h7;
   endsequence
   bclk_route_a: assert property (
      quiet |-> CORE_O.if_bclk == ($past(e_bclk, 3) ^ rg[5][3]))
      else $error("bit clock route");
   wclk_route_a: assert property (
      quiet |-> CORE_O.if_wclk == $past(e_wclk, 3)) else $error("word clock");
   din_route_a: assert property (
      quiet |-> CORE_O.if_din == $past(e_din, 3)) else $error("data in");
   loop_data_a: assert property (
      quiet ##0 rg[1][1:0] == 2'h2 |-> PIN_O.dout == $past(sd, 3)
      && PIN_O.sec_dout == $past(PIN_I.din, 3)) else $error("loopback");
   sec_out_a: assert property (
      quiet |-> (rg[1][6] || PIN_O.sec_bclk == $past(PIN_I.bclk, 3)) &&
      PIN_O.sec_wclk == (rg[1][2] ? $past(fs, 3) : $past(PIN_I.wclk, 3)))
      else $error("secondary outputs");
   pin_out_a: assert property (
      quiet |-> (!PIN_O.wclk_oe ||
      PIN_O.wclk == (rg[1][5] ? $past(sw, 3) : $past(fs, 3))) &&
      (!PIN_O.bclk_oe || !rg[1][7] ||
      PIN_O.bclk == ($past(sb, 3) ^ rg[5][3]))) else $error("pin outputs");
   pin_dir_a: assert property (
      quiet |-> PIN_O.bclk_oe == rg[3][3] && PIN_O.wclk_oe == rg[3][2] &&
      (PIN_O.bclk_oe || !PIN_O.bclk) && (PIN_O.wclk_oe || !PIN_O.wclk))
      else $error("pin direction");
   gen_call_a: assert property (
      quiet |-> CORE_O.gc_accept == ($past(GC_DET_I) & rg[2][5]))
      else $error("general call");
   buf_pd_a: assert property (
      quiet ##0 $past(CODEC_PD_I) == $past(CODEC_PD_I, 2) |->
      CORE_O.buf_pd == ($past(CODEC_PD_I) & rg[5][2])) else $error("buffers");
   div_pwr_a: assert property (
      quiet |-> CORE_O.div_pwr == rg[6][7] && (rg[6][7] || rg[1][7] ||
      !PIN_O.bclk_oe || PIN_O.bclk == rg[5][3])) else $error("divider power");
endmodule
bind apc_top apc_checker i_chk (.SYS_CLK_I, .NRST_I, .HSEL_I, .HADDR_I,
   .HTRANS_I, .HWRITE_I, .HWDATA_I, .PIN_I, .PIN_O, .CODEC_PD_I,
   .GC_DET_I, .CORE_O);
`default_nettype wire

// *** verification/testbench.sv ***
// testbench: register, routing and divider tests for apc_top.
// assumes apc_checker is bound and apc_partner drives the pins.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import apc_pkg::*;
   localparam logic [7:0] IDXS [7] = '{IDX_IF_DIR, IDX_PORT_SET3, IDX_BDIV,
      IDX_SEC_SRC, IDX_PRI_SEC, IDX_OUT_ROUTE, IDX_MISC};
   localparam logic [7:0] MSKS [7] = '{MSK_IF_DIR, MSK_PORT_SET3, MSK_BDIV,
      MSK_SEC_SRC, MSK_PRI_SEC, MSK_OUT_ROUTE, MSK_MISC};
   logic         clk = 1'b0;
   logic         rst_n = 1'b0;
   logic         hsel = 1'b0;
   logic [31:0]  haddr = 32'h0;
   logic [1:0]   htrans = 2'h0;
   logic         hwrite = 1'b0;
   logic [31:0]  hwdata = 32'h0;
   logic         pd = 1'b0;
   logic         gc = 1'b0;
   logic         hready;
   logic         hresp;
   logic [31:0]  hrdata;
   apc_pin_in_t  pin_i;
   apc_pin_out_t pin_o;
   int           errors = 0;
   int           check_count = 0;
   int           cyc = 0;
   apc_top i_dut (.SYS_CLK_I(clk), .NRST_I(rst_n), .HSEL_I(hsel),
      .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
      .HWDATA_I(hwdata), .HREADY_I(hready), .HREADYOUT_O(hready),
      .HRESP_O(hresp), .HRDATA_O(hrdata), .PIN_I(pin_i), .PIN_O(pin_o),
      .CODEC_PD_I(pd), .GC_DET_I(gc), .CORE_O());
   apc_partner i_far (.CLK_I(clk), .NRST_I(rst_n), .DUT_I(pin_o),
      .PIN_O(pin_i));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      pd <= cyc[4];
      gc <= cyc[3];
      if (cyc == 15000) begin
         errors++;
         complete_run;
      end
   end
   task automatic xfer(input logic w, input logic [7:0] idx,
                       input logic [7:0] d, output logic [7:0] q);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {22'h0, idx, 2'h0};
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      q = hrdata[7:0];
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      xfer(1'b1, idx, d, q);
   endtask
   task automatic rd(input logic [7:0] idx, m, exp);
      logic [7:0] q;
      xfer(1'b0, idx, 8'h00, q);
      chk8(q & m, exp);
      chk8({7'h0, hresp}, 8'h00);
   endtask
   // counts rising edges of the bit-clock pin over a window
   task automatic div_case(input logic [1:0] src, input logic [7:0] bd,
                           input int w, input int e);
      int n;
      logic last;
      n = 0;
      wr(IDX_PORT_SET3, {6'h0, src});
      wr(IDX_BDIV, bd);
      repeat (20) @(posedge clk);
      last = pin_o.bclk;
      repeat (w) begin
         @(posedge clk);
         n += int'(pin_o.bclk === 1'b1 && last === 1'b0);
         last = pin_o.bclk;
      end
      check_count++;
      if (n < e - (e + 63) / 64 || n > e + (e + 63) / 64) begin
         errors++;
         $display("unexpected at %0t: %0d edges want %0d", $time, n, e);
      end
      rd(IDX_STATUS, 8'h0D, {4'h0, 2'h3, 1'b0, bd[7]});
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 7; i++) begin
         rd(IDXS[i], 8'hFF, i == 2 ? RST_BDIV : RST_REG);
      end
      rd(IDX_STATUS, 8'hFF, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 7; i++) begin
         wr(IDXS[i], i == 1 ? 8'hFD : 8'hFF);
         rd(IDXS[i], 8'hFF, MSKS[i] & (i == 1 ? 8'hFD : 8'hFF));
         wr(IDXS[i], i == 2 ? RST_BDIV : RST_REG);
      end
      wr(8'h10, 8'hFF);
      rd(8'h10, 8'hFF, 8'h00);
      $display("test access done");
      for (int i = 0; i < 8; i++) begin
         wr(IDX_SEC_SRC, {1'b0, i[1:0], i[2:1], 2'h0, i[0]});
         wr(IDX_PRI_SEC, {4'h0, i[0], i[1], 1'b0, i[2]});
         wr(IDX_OUT_ROUTE, {i[0], i[1], i[2], 2'h0, i[0], 2'h2});
         wr(IDX_IF_DIR, {4'h0, i[1], i[2], 2'h0});
         wr(IDX_PORT_SET3, {4'h0, i[2], i[0], 2'h0});
         wr(IDX_MISC, {2'h0, i[1], 5'h0});
         repeat (64) @(posedge clk);
      end
      $display("test routing done");
      wr(IDX_IF_DIR, 8'h0C);
      wr(IDX_OUT_ROUTE, 8'h02);
      wr(IDX_PORT_SET3, 8'h08);
      repeat (8) @(posedge clk);
      chk8({7'h0, pin_o.bclk}, 8'h01);
      div_case(2'h0, 8'h82, 1200, 150);
      div_case(2'h1, 8'h82, 1200, 100);
      div_case(2'h0, 8'h81, 1200, 300);
      div_case(2'h0, 8'h80, 2048, 4);
      div_case(2'h0, 8'hFF, 2032, 4);
      div_case(2'h0, 8'h02, 400, 0);
      $display("test divider done");
      complete_run;
   end
endmodule
`default_nettype wire
